// ### inc/cbx_pkg.sv
// Shared constants and types for the bit/branch execution core.
// Assumes a 32-bit AHB-Lite register port with word-only accesses.
package cbx_pkg;
  // Register byte offsets on the bus.
  localparam logic [11:0] A_INSTR  = 12'h000;
  localparam logic [11:0] A_ACCUM  = 12'h004;
  localparam logic [11:0] A_STATUS = 12'h008;
  localparam logic [11:0] A_PC     = 12'h00C;
  localparam logic [11:0] A_BANK   = 12'h010;
  localparam logic [11:0] A_CYCLES = 12'h014;
  // File window select, taken from address bits 11:10.
  localparam logic [1:0]  A_FILE_SEL = 2'h1;
  // Status register bit positions.
  localparam int ST_C    = 0;
  localparam int ST_HC   = 1;
  localparam int ST_Z    = 2;
  localparam int ST_DROP = 8;
  localparam int ST_BUSY = 9;
  // Widths fixed by the instruction set.
  localparam int FILE_AW = 7;
  localparam int OFS_W   = 9;
  localparam int INSTR_W = 23;
  // Reset values.
  localparam logic [7:0]  ACCUM_RST = 8'h00;
  localparam logic [31:0] CYC_RST   = 32'h0000_0000;
  // Destination select values.
  localparam logic DEST_ACCUM = 1'b0;
  localparam logic DEST_FILE  = 1'b1;
  // Operation codes held in the instruction register.
  typedef enum logic [2:0] {
    OP_AND  = 3'h0,
    OP_ADDC = 3'h1,
    OP_ASR  = 3'h2,
    OP_CLR  = 3'h3,
    OP_SET  = 3'h4,
    OP_JLIT = 3'h5,
    OP_JACC = 3'h6,
    OP_NOP  = 3'h7
  } cbx_op_e;
  // Instruction word, low 23 bits of the written data.
  typedef struct packed {
    cbx_op_e           op;
    logic [OFS_W-1:0]  lit;
    logic              dest;
    logic [2:0]        bitsel;
    logic [FILE_AW-1:0] faddr;
  } cbx_instr_s;
  // Status flags.
  typedef struct packed {
    logic z;
    logic hc;  // Half carry, out of bit 3.
    logic c;
  } cbx_flags_s;
  // Execution sequencer states.
  typedef enum logic [2:0] {
    S_IDLE = 3'b001,
    S_EXEC = 3'b010,
    S_NOP  = 3'b100
  } cbx_state_e;
endpackage

// ### core/cbx_alu.sv
// Combinational result and flag unit of the execution core.
// Assumes operands are stable for the whole execute cycle.
`timescale 1ns/1ps
module cbx_alu (
  // Operation and operands.
  input  wire cbx_pkg::cbx_op_e    op_i,
  input  wire logic [7:0]          accum_i,
  input  wire logic [7:0]          file_i,
  input  wire logic [2:0]          bitsel_i,
  input  wire cbx_pkg::cbx_flags_s flags_i,
  // Result and next flags.
  output logic [7:0]               result_o,
  output cbx_pkg::cbx_flags_s      flags_o
);
  logic [8:0] sum9;  // Full sum with carry out.
  logic [4:0] half5; // Low nibble sum for half carry.
  logic [7:0] mask;  // One-hot bit select.

  // Flags not named by an operation keep their value.
  always_comb begin
    sum9  = {1'b0, accum_i} + {1'b0, file_i} + {8'h00, flags_i.c};
    half5 = {1'b0, accum_i[3:0]} + {1'b0, file_i[3:0]}
            + {4'h0, flags_i.c};
    mask  = 8'h01 << bitsel_i;
    result_o = file_i;
    flags_o  = flags_i;
    case (op_i)
      cbx_pkg::OP_AND: begin
        result_o  = accum_i & file_i;
        flags_o.z = (result_o == 8'h00);
      end
      cbx_pkg::OP_ADDC: begin
        result_o   = sum9[7:0];
        flags_o.c  = sum9[8];
        flags_o.hc = half5[4];
        flags_o.z  = (result_o == 8'h00);
      end
      cbx_pkg::OP_ASR: begin
        result_o  = {file_i[7], file_i[7:1]};
        flags_o.c = file_i[0];
        flags_o.z = (result_o == 8'h00);
      end
      cbx_pkg::OP_CLR: result_o = file_i & ~mask;
      cbx_pkg::OP_SET: result_o = file_i | mask;
      default: result_o = file_i;
    endcase
  end
endmodule

// ### core/cbx_ahb_slave.sv
// AHB-Lite slave front end: address capture, read wait state.
// Assumes word-only single transfers; the response is always OKAY.
`timescale 1ns/1ps
module cbx_ahb_slave #(
  parameter int AW = 12
) (
  // Clock and reset.
  input  wire logic          clk_i,
  input  wire logic          reset_n_i,
  // Bus address phase.
  input  wire logic          hsel_i,
  input  wire logic [31:0]   haddr_i,
  input  wire logic [1:0]    htrans_i,
  input  wire logic          hwrite_i,
  input  wire logic          hready_i,
  // Bus answer.
  output logic               hreadyout_o,
  output logic               hresp_o,
  output logic [31:0]        hrdata_o,
  // Register side.
  output logic               wr_o,
  output logic [AW-1:0]      addr_o,
  input  wire logic [31:0]   rd_data_i
);
  logic take;    // Address phase accepted.
  logic rd_pend; // Read waiting for its data.

  assign take = hsel_i & hready_i & htrans_i[1];

  // Capture the address; a read costs one wait state so the
  // data always comes from a flop and never races a write.
  always_ff @(posedge clk_i or negedge reset_n_i) begin
    if (!reset_n_i) begin
      addr_o      <= '0;
      wr_o        <= 1'b0;
      rd_pend     <= 1'b0;
      hreadyout_o <= 1'b1;
      hrdata_o    <= 32'h0000_0000;
    end else begin
      wr_o    <= take & hwrite_i;
      rd_pend <= take & ~hwrite_i;
      if (take) begin
        addr_o <= haddr_i[AW-1:0];
      end
      if (take & ~hwrite_i) begin
        hreadyout_o <= 1'b0;
      end else if (rd_pend) begin
        hrdata_o    <= rd_data_i;
        hreadyout_o <= 1'b1;
      end
    end
  end

  // Every transfer ends OKAY.
  always_ff @(posedge clk_i or negedge reset_n_i) begin
    if (!reset_n_i) begin
      hresp_o <= 1'b0;
    end else begin
      hresp_o <= 1'b0;
    end
  end
endmodule

// ### core/cbx_exec_core.sv
// Execution core for the logic, shift, bit and relative jump group.
// Assumes an AHB-Lite master that issues one word transfer at a time.
//
// Contract
// - AND accumulator with file, zero only.
// - Destination bit picks accumulator or file.
// - File operand is 7-bit bank address.
// - Add with carry sets all three flags.
// - Shift right keeps MSB, LSB to carry.
// - Clear selected bit, flags unchanged.
// - Set selected bit, flags unchanged.
// - Counter plus one plus signed literal.
// - Literal jump always takes two cycles.
// - Counter plus one plus unsigned accumulator.
// - Counter change adds one idle cycle.
//
// Register access over AHB-Lite and the address map were decided locally.
`timescale 1ns/1ps
module cbx_exec_core #(
  parameter int PC_W   = 15,
  parameter int BANK_W = 2
) (
  // Clock and reset.
  input  wire logic        clk_i,
  input  wire logic        reset_n_i,
  // AHB-Lite slave port.
  input  wire logic        hsel_i,
  input  wire logic [31:0] haddr_i,
  input  wire logic [1:0]  htrans_i,
  input  wire logic        hwrite_i,
  input  wire logic [2:0]  hsize_i,
  input  wire logic        hready_i,
  input  wire logic [31:0] hwdata_i,
  output logic             hreadyout_o,
  output logic             hresp_o,
  output logic [31:0]      hrdata_o
);
  localparam int DEPTH = 128 << BANK_W; // Bytes of file space.
  localparam int MI_W  = cbx_pkg::FILE_AW + BANK_W;

  logic [7:0]            file_mem [DEPTH]; // File registers.
  cbx_pkg::cbx_state_e   state;       // Sequencer state.
  cbx_pkg::cbx_instr_s   instr;       // Latched instruction.
  cbx_pkg::cbx_flags_s   flags;       // Status flags.
  cbx_pkg::cbx_flags_s   alu_flags;   // Flags after the op.
  logic [7:0]            accum;       // Accumulator.
  logic [PC_W-1:0]       pc;          // Program counter.
  logic [BANK_W-1:0]     bank;        // Current data bank.
  logic [31:0]           cycles;      // Instruction cycles.
  logic                  drop;        // Launch refused.
  logic                  bus_wr;      // Write data phase.
  logic [11:0]           bus_addr;    // Captured address.
  logic [31:0]           rd_data;     // Read mux.
  logic [7:0]            f_val;       // Operand from file.
  logic [7:0]            alu_res;     // Operation result.
  logic [MI_W-1:0]       exec_idx;    // Operand location.
  logic [MI_W-1:0]       bus_idx;     // Bus window location.
  logic                  file_win;    // Bus hits the window.
  logic                  is_jump;     // Counter-changing op.
  logic                  to_file;     // Result goes to file.
  logic                  exec_we;     // Core writes the file.
  logic                  launch;      // Instruction write.
  logic [PC_W-1:0]       jlit_tgt;    // Literal jump target.
  logic [PC_W-1:0]       jacc_tgt;    // Accumulator target.

  // The bus front end owns the handshake timing.
  cbx_ahb_slave #(
    .AW(12)
  ) cbx_ahb_slave_inst (
    .clk_i       (clk_i),
    .reset_n_i   (reset_n_i),
    .hsel_i      (hsel_i),
    .haddr_i     (haddr_i),
    .htrans_i    (htrans_i),
    .hwrite_i    (hwrite_i),
    .hready_i    (hready_i),
    .hreadyout_o (hreadyout_o),
    .hresp_o     (hresp_o),
    .hrdata_o    (hrdata_o),
    .wr_o        (bus_wr),
    .addr_o      (bus_addr),
    .rd_data_i   (rd_data)
  );

  // Result and flag arithmetic.
  cbx_alu cbx_alu_inst (
    .op_i     (instr.op),
    .accum_i  (accum),
    .file_i   (f_val),
    .bitsel_i (instr.bitsel),
    .flags_i  (flags),
    .result_o (alu_res),
    .flags_o  (alu_flags)
  );

  assign exec_idx = {bank, instr.faddr};
  assign bus_idx  = {bank, bus_addr[8:2]};
  assign file_win = (bus_addr[11:10] == cbx_pkg::A_FILE_SEL);
  assign f_val    = file_mem[exec_idx];
  assign launch   = bus_wr && (bus_addr == cbx_pkg::A_INSTR);
  assign is_jump  = (instr.op == cbx_pkg::OP_JLIT) ||
                    (instr.op == cbx_pkg::OP_JACC);
  assign to_file  = (instr.op == cbx_pkg::OP_CLR) ||
                    (instr.op == cbx_pkg::OP_SET) ||
                    ((instr.op == cbx_pkg::OP_AND ||
                      instr.op == cbx_pkg::OP_ADDC ||
                      instr.op == cbx_pkg::OP_ASR) &&
                     instr.dest == cbx_pkg::DEST_FILE);
  assign exec_we  = (state == cbx_pkg::S_EXEC) && to_file;
  assign jlit_tgt = pc + PC_W'(1) +
                    {{(PC_W-cbx_pkg::OFS_W){instr.lit[8]}}, instr.lit};
  assign jacc_tgt = pc + PC_W'(1) + {{(PC_W-8){1'b0}}, accum};

  // Sequencer: one execute cycle, plus an idle cycle for jumps.
  always_ff @(posedge clk_i or negedge reset_n_i) begin
    if (!reset_n_i) begin
      state <= cbx_pkg::S_IDLE;
    end else begin
      case (state)
        cbx_pkg::S_IDLE: begin
          if (launch) begin
            state <= cbx_pkg::S_EXEC;
          end
        end
        cbx_pkg::S_EXEC: begin
          if (is_jump) begin
            state <= cbx_pkg::S_NOP;
          end else begin
            state <= cbx_pkg::S_IDLE;
          end
        end
        cbx_pkg::S_NOP: state <= cbx_pkg::S_IDLE;
        default: state <= cbx_pkg::S_IDLE;
      endcase
    end
  end

  // Instruction latch; a launch while busy is refused, not queued,
  // so software must poll the busy bit between launches.
  always_ff @(posedge clk_i or negedge reset_n_i) begin
    if (!reset_n_i) begin
      instr <= '0;
    end else if (launch && state == cbx_pkg::S_IDLE) begin
      instr <= cbx_cast(hwdata_i);
    end
  end

  // Refused-launch flag; a new refusal beats a clear.
  always_ff @(posedge clk_i or negedge reset_n_i) begin
    if (!reset_n_i) begin
      drop <= 1'b0;
    end else if (launch && state != cbx_pkg::S_IDLE) begin
      drop <= 1'b1;
    end else if (bus_wr && bus_addr == cbx_pkg::A_STATUS &&
                 hwdata_i[cbx_pkg::ST_DROP]) begin
      drop <= 1'b0;
    end
  end

  // Accumulator: the core wins over a bus write.
  always_ff @(posedge clk_i or negedge reset_n_i) begin
    if (!reset_n_i) begin
      accum <= cbx_pkg::ACCUM_RST;
    end else if (state == cbx_pkg::S_EXEC) begin
      if (!to_file && !is_jump && instr.op != cbx_pkg::OP_NOP) begin
        accum <= alu_res;
      end
    end else if (bus_wr && bus_addr == cbx_pkg::A_ACCUM) begin
      accum <= hwdata_i[7:0];
    end
  end

  // Status flags; jumps and bit ops pass them through unchanged.
  always_ff @(posedge clk_i or negedge reset_n_i) begin
    if (!reset_n_i) begin
      flags <= '0;
    end else if (state == cbx_pkg::S_EXEC) begin
      flags <= alu_flags;
    end else if (bus_wr && bus_addr == cbx_pkg::A_STATUS) begin
      flags.c  <= hwdata_i[cbx_pkg::ST_C];
      flags.hc <= hwdata_i[cbx_pkg::ST_HC];
      flags.z  <= hwdata_i[cbx_pkg::ST_Z];
    end
  end

  // Program counter; plain ops step it, jumps load their target.
  always_ff @(posedge clk_i or negedge reset_n_i) begin
    if (!reset_n_i) begin
      pc <= '0;
    end else if (state == cbx_pkg::S_EXEC) begin
      case (instr.op)
        cbx_pkg::OP_JLIT: pc <= jlit_tgt;
        cbx_pkg::OP_JACC: pc <= jacc_tgt;
        default: pc <= pc + PC_W'(1);
      endcase
    end else if (bus_wr && bus_addr == cbx_pkg::A_PC) begin
      pc <= hwdata_i[PC_W-1:0];
    end
  end

  // Bank select, written by software only.
  always_ff @(posedge clk_i or negedge reset_n_i) begin
    if (!reset_n_i) begin
      bank <= '0;
    end else if (bus_wr && bus_addr == cbx_pkg::A_BANK) begin
      bank <= hwdata_i[BANK_W-1:0];
    end
  end

  // Cycle counter, counting execute and idle cycles alike.
  always_ff @(posedge clk_i or negedge reset_n_i) begin
    if (!reset_n_i) begin
      cycles <= cbx_pkg::CYC_RST;
    end else if (state != cbx_pkg::S_IDLE) begin
      cycles <= cycles + 32'h0000_0001;
    end
  end

  // File space has no reset; the core write takes priority.
  always_ff @(posedge clk_i) begin
    if (exec_we) begin
      file_mem[exec_idx] <= alu_res;
    end else if (bus_wr && file_win) begin
      file_mem[bus_idx] <= hwdata_i[7:0];
    end
  end

  // Read mux; unmapped addresses read as zero.
  always_comb begin
    rd_data = 32'h0000_0000;
    if (file_win) begin
      rd_data[7:0] = file_mem[bus_idx];
    end else begin
      case (bus_addr)
        cbx_pkg::A_INSTR:  rd_data[22:0] = instr;
        cbx_pkg::A_ACCUM:  rd_data[7:0] = accum;
        cbx_pkg::A_STATUS: begin
          rd_data[cbx_pkg::ST_C]    = flags.c;
          rd_data[cbx_pkg::ST_HC]   = flags.hc;
          rd_data[cbx_pkg::ST_Z]    = flags.z;
          rd_data[cbx_pkg::ST_DROP] = drop;
          rd_data[cbx_pkg::ST_BUSY] = (state != cbx_pkg::S_IDLE);
        end
        cbx_pkg::A_PC:     rd_data[PC_W-1:0] = pc;
        cbx_pkg::A_BANK:   rd_data[BANK_W-1:0] = bank;
        cbx_pkg::A_CYCLES: rd_data = cycles;
        default:           rd_data = 32'h0000_0000;
      endcase
    end
  end

  // Slice the instruction word out of the bus data.
  function automatic cbx_pkg::cbx_instr_s cbx_cast(
    input logic [31:0] d
  );
    cbx_cast = d[cbx_pkg::INSTR_W-1:0];
  endfunction

  // Checks below watch the core's own state and results.
  default clocking cb @(posedge clk_i); endclocking
  default disable iff (!reset_n_i);

  logic ex;
  assign ex = (state == cbx_pkg::S_EXEC);

  sequence s_nop_then_idle;
    (state == cbx_pkg::S_NOP) ##1 (state == cbx_pkg::S_IDLE);
  endsequence

  sequence s_jump_exec;
    ex && is_jump;
  endsequence

  a_and_zero_only: assert property (
    ex && instr.op == cbx_pkg::OP_AND |=>
      flags.z == ($past(accum & f_val) == 8'h00) &&
      flags.c == $past(flags.c) && flags.hc == $past(flags.hc))
    else $error("AND flag update wrong");

  a_dest_accum: assert property (
    ex && instr.op == cbx_pkg::OP_AND &&
    instr.dest == cbx_pkg::DEST_ACCUM |=>
      accum == $past(accum & f_val))
    else $error("AND result not in accumulator");

  a_file_index: assert property (
    exec_we |=>
      file_mem[{$past(bank), $past(instr.faddr)}] == $past(alu_res))
    else $error("file write outside bank offset");

  a_addc_sum: assert property (
    ex && instr.op == cbx_pkg::OP_ADDC &&
    instr.dest == cbx_pkg::DEST_ACCUM |=>
      {flags.c, accum} == $past({1'b0, accum} + {1'b0, f_val} +
                                {8'h00, flags.c}))
    else $error("add with carry wrong");

  a_asr_carry: assert property (
    ex && instr.op == cbx_pkg::OP_ASR &&
    instr.dest == cbx_pkg::DEST_ACCUM |=>
      flags.c == $past(f_val[0]) && accum[7] == $past(f_val[7]) &&
      accum[6:0] == $past(f_val[7:1]))
    else $error("shift right wrong");

  a_clr_flags: assert property (
    ex && instr.op == cbx_pkg::OP_CLR |=>
      $stable(flags) && f_val[$past(instr.bitsel)] == 1'b0)
    else $error("bit clear wrong");

  a_set_flags: assert property (
    ex && instr.op == cbx_pkg::OP_SET |=>
      $stable(flags) && f_val[$past(instr.bitsel)] == 1'b1)
    else $error("bit set wrong");

  a_jlit_target: assert property (
    ex && instr.op == cbx_pkg::OP_JLIT |=>
      pc - $past(pc) == PC_W'(1) +
        {{(PC_W-9){$past(instr.lit[8])}}, $past(instr.lit)} &&
      $stable(flags))
    else $error("literal jump target wrong");

  a_jump_two_cyc: assert property (
    s_jump_exec |=> s_nop_then_idle)
    else $error("jump not two cycles");

  a_jacc_target: assert property (
    ex && instr.op == cbx_pkg::OP_JACC |=>
      pc == $past(pc) + PC_W'(1) + {{(PC_W-8){1'b0}}, $past(accum)}
      && $stable(flags))
    else $error("accumulator jump target wrong");

  a_nop_quiet: assert property (
    state == cbx_pkg::S_NOP |=> $stable(accum) && $stable(flags) &&
      $stable(pc))
    else $error("idle cycle changed state");

  a_single_cycle: assert property (
    ex && !is_jump |=> state == cbx_pkg::S_IDLE &&
      pc == $past(pc) + PC_W'(1))
    else $error("plain op not one cycle");
endmodule

// ### dv/test_cbx_exec_core.sv
// Self-checking bench for the logic, shift, bit and relative jump core.
// Assumes the core is the only slave on an AHB-Lite bus driven from here.
`timescale 1ns/1ps
module test_cbx_exec_core;
  // Bench side of the bus and the run counters.
  logic             clk = 1'b0; // Core clock, 100 MHz.
  logic             rst_n;      // Asynchronous reset, active low.
  logic             hsel;       // Slave select.
  logic [31:0]      haddr;      // Byte address.
  logic [1:0]       htrans;     // Transfer type.
  logic             hwrite;     // Write strobe.
  logic [31:0]      hwdata;     // Write data.
  wire logic        hready;     // The one slave's ready is the bus ready.
  wire logic        hresp;      // Response code.
  wire logic [31:0] hrdata;     // Read data.
  int               fails;      // Mismatches counted so far.
  int               n_checks;   // Comparisons made so far.
  logic [31:0]      rd;         // Word taken at the last data edge.
  logic [31:0]      c0;         // Cycle counter before an instruction.

  // Device under test with its default widths.
  cbx_exec_core cbx_exec_core_inst (
    .clk_i       (clk),
    .reset_n_i   (rst_n),
    .hsel_i      (hsel),
    .haddr_i     (haddr),
    .htrans_i    (htrans),
    .hwrite_i    (hwrite),
    .hsize_i     (3'h2),
    .hready_i    (hready),
    .hwdata_i    (hwdata),
    .hreadyout_o (hready),
    .hresp_o     (hresp),
    .hrdata_o    (hrdata)
  );

  // Free running clock, 10 ns period.
  always #5 clk = ~clk;

  // Count one comparison and report a mismatch at once.
  task automatic chk(input logic [31:0] got, input logic [31:0] exp);
    n_checks++;
    if (got !== exp) begin
      fails++;
      $display("BAD t=%0t got=%h exp=%h", $time, got, exp);
    end
  endtask

  // Print the counts and the verdict, then stop the run.
  task automatic end_of_test();
    $display("checks=%0d fails=%0d", n_checks, fails);
    if (fails == 0 && n_checks > 0) begin
      $display("SIMULATION PASSED");
    end else begin
      $display("SIMULATION FAILED");
    end
    $finish;
  endtask

  // One single word transfer, entered just after a rising edge.
  // Every phase is held until ready is seen high, never a fixed count.
  task automatic xfer(input logic wr, input logic [31:0] a,
                      input logic [31:0] d);
    hsel   <= 1'b1;
    htrans <= 2'h2;
    haddr  <= a;
    hwrite <= wr;
    do @(posedge clk); while (hready !== 1'b1);
    htrans <= 2'h0;
    hwdata <= d;
    do @(posedge clk); while (hready !== 1'b1);
    rd = hrdata;
    chk({31'h0, hresp}, 32'h0000_0000);
  endtask

  // Short forms for a register write and a register read.
  task automatic wr(input logic [31:0] a, input logic [31:0] d);
    xfer(1'b1, a, d);
  endtask
  task automatic rdw(input logic [31:0] a);
    xfer(1'b0, a, 32'h0000_0000);
  endtask

  // Instruction word: op, literal, destination, bit index, file address.
  function automatic logic [31:0] mk(input cbx_pkg::cbx_op_e op,
    input logic [8:0] lit, input logic dst, input logic [2:0] b,
    input logic [6:0] f);
    return {9'h000, op, lit, dst, b, f};
  endfunction

  // Byte address of file location f in the current bank.
  function automatic logic [31:0] fa(input logic [6:0] f);
    return 32'h0000_0400 + {23'h0, f, 2'b00};
  endfunction

  // Issue one instruction, poll until idle, and check its cycle cost.
  task automatic exec(input logic [31:0] ins, input logic [31:0] ncyc);
    int n;
    rdw(cbx_pkg::A_CYCLES);
    c0 = rd;
    wr(cbx_pkg::A_INSTR, ins);
    n = 0;
    do begin
      rdw(cbx_pkg::A_STATUS);
      n++;
    end while (rd[cbx_pkg::ST_BUSY] !== 1'b0 && n < 20);
    rdw(cbx_pkg::A_CYCLES);
    chk(rd - c0, ncyc);
  endtask

  // AND into both destinations; carry and half carry must survive.
  task automatic t_and();
    rdw(32'h0000_0020);
    chk(rd, 32'h0000_0000);
    wr(cbx_pkg::A_STATUS, 32'h0000_0003);
    wr(cbx_pkg::A_ACCUM, 32'h0000_00F0);
    wr(fa(7'h05), 32'h0000_003C);
    wr(cbx_pkg::A_PC, 32'h0000_0010);
    exec(mk(cbx_pkg::OP_AND, 9'h000, cbx_pkg::DEST_ACCUM, 3'h0, 7'h05),
         32'h1);
    rdw(cbx_pkg::A_ACCUM);
    chk(rd, 32'h0000_0030);
    rdw(fa(7'h05));
    chk(rd, 32'h0000_003C);
    rdw(cbx_pkg::A_STATUS);
    chk(rd & 32'h7, 32'h0000_0003);
    rdw(cbx_pkg::A_PC);
    chk(rd, 32'h0000_0011);
    wr(fa(7'h06), 32'h0000_000F);
    exec(mk(cbx_pkg::OP_AND, 9'h000, cbx_pkg::DEST_FILE, 3'h0, 7'h06),
         32'h1);
    rdw(fa(7'h06));
    chk(rd, 32'h0000_0000);
    rdw(cbx_pkg::A_ACCUM);
    chk(rd, 32'h0000_0030);
    rdw(cbx_pkg::A_STATUS);
    chk(rd & 32'h7, 32'h0000_0007);
    $display("test and done");
  endtask

  // Add with carry at the top file address, then a half carry alone.
  task automatic t_addc();
    wr(cbx_pkg::A_STATUS, 32'h0000_0001);
    wr(cbx_pkg::A_ACCUM, 32'h0000_000F);
    wr(fa(7'h7F), 32'h0000_00F1);
    exec(mk(cbx_pkg::OP_ADDC, 9'h000, cbx_pkg::DEST_FILE, 3'h0, 7'h7F),
         32'h1);
    rdw(fa(7'h7F));
    chk(rd, 32'h0000_0001);
    rdw(cbx_pkg::A_STATUS);
    chk(rd & 32'h7, 32'h0000_0003);
    wr(cbx_pkg::A_STATUS, 32'h0000_0000);
    wr(cbx_pkg::A_ACCUM, 32'h0000_0008);
    wr(fa(7'h00), 32'h0000_0008);
    exec(mk(cbx_pkg::OP_ADDC, 9'h000, cbx_pkg::DEST_ACCUM, 3'h0, 7'h00),
         32'h1);
    rdw(cbx_pkg::A_ACCUM);
    chk(rd, 32'h0000_0010);
    rdw(cbx_pkg::A_STATUS);
    chk(rd & 32'h7, 32'h0000_0002);
    $display("test addc done");
  endtask

  // Shift keeps the top bit; half carry is left alone by the shift.
  task automatic t_asr();
    wr(cbx_pkg::A_STATUS, 32'h0000_0004);
    wr(fa(7'h01), 32'h0000_0081);
    exec(mk(cbx_pkg::OP_ASR, 9'h000, cbx_pkg::DEST_FILE, 3'h0, 7'h01),
         32'h1);
    rdw(fa(7'h01));
    chk(rd, 32'h0000_00C0);
    rdw(cbx_pkg::A_STATUS);
    chk(rd & 32'h7, 32'h0000_0001);
    wr(cbx_pkg::A_STATUS, 32'h0000_0002);
    wr(fa(7'h02), 32'h0000_0001);
    exec(mk(cbx_pkg::OP_ASR, 9'h000, cbx_pkg::DEST_ACCUM, 3'h0, 7'h02),
         32'h1);
    rdw(cbx_pkg::A_ACCUM);
    chk(rd, 32'h0000_0000);
    rdw(cbx_pkg::A_STATUS);
    chk(rd & 32'h7, 32'h0000_0007);
    $display("test asr done");
  endtask

  // Every bit index set and cleared; the flags must not move.
  task automatic t_bits();
    for (int b = 0; b < 8; b++) begin
      wr(cbx_pkg::A_STATUS, 32'h0000_0005);
      wr(fa(7'h09), 32'h0000_0000);
      wr(fa(7'h0A), 32'h0000_00FF);
      exec(mk(cbx_pkg::OP_SET, 9'h000, 1'b0, b[2:0], 7'h09),
           32'h1);
      exec(mk(cbx_pkg::OP_CLR, 9'h000, 1'b0, b[2:0], 7'h0A),
           32'h1);
      rdw(fa(7'h09));
      chk(rd, 32'h0000_0001 << b);
      rdw(fa(7'h0A));
      chk(rd, ~(32'h0000_0001 << b) & 32'h0000_00FF);
      rdw(cbx_pkg::A_STATUS);
      chk(rd & 32'h7, 32'h0000_0005);
    end
    $display("test bits done");
  endtask

  // Both jumps at the edges of their ranges, including counter wrap.
  task automatic t_jumps();
    wr(cbx_pkg::A_STATUS, 32'h0000_0002);
    wr(cbx_pkg::A_PC, 32'h0000_0100);
    exec(mk(cbx_pkg::OP_JLIT, 9'h100, 1'b0, 3'h0, 7'h00),
         32'h2);
    rdw(cbx_pkg::A_PC);
    chk(rd, 32'h0000_0001);
    wr(cbx_pkg::A_PC, 32'h0000_7FFF);
    exec(mk(cbx_pkg::OP_JLIT, 9'h0FF, 1'b0, 3'h0, 7'h00),
         32'h2);
    rdw(cbx_pkg::A_PC);
    chk(rd, 32'h0000_00FF);
    wr(cbx_pkg::A_ACCUM, 32'h0000_00FF);
    wr(cbx_pkg::A_PC, 32'h0000_0010);
    exec(mk(cbx_pkg::OP_JACC, 9'h000, 1'b0, 3'h0, 7'h00),
         32'h2);
    rdw(cbx_pkg::A_PC);
    chk(rd, 32'h0000_0110);
    rdw(cbx_pkg::A_STATUS);
    chk(rd & 32'h7, 32'h0000_0002);
    $display("test jumps done");
  endtask

  // No-op, bank select, then a launch refused while a jump is busy.
  task automatic t_misc();
    logic [31:0] jw;
    jw = mk(cbx_pkg::OP_JLIT, 9'h001, 1'b0, 3'h0, 7'h00);
    wr(cbx_pkg::A_STATUS, 32'h0000_0005);
    wr(cbx_pkg::A_PC, 32'h0000_0020);
    exec(mk(cbx_pkg::OP_NOP, 9'h000, 1'b0, 3'h0, 7'h00),
         32'h1);
    rdw(cbx_pkg::A_PC);
    chk(rd, 32'h0000_0021);
    rdw(cbx_pkg::A_STATUS);
    chk(rd & 32'h7, 32'h0000_0005);
    wr(cbx_pkg::A_BANK, 32'h0000_0001);
    wr(fa(7'h05), 32'h0000_0055);
    wr(cbx_pkg::A_ACCUM, 32'h0000_00FF);
    exec(mk(cbx_pkg::OP_AND, 9'h000, cbx_pkg::DEST_ACCUM, 3'h0, 7'h05),
         32'h1);
    rdw(cbx_pkg::A_ACCUM);
    chk(rd, 32'h0000_0055);
    rdw(cbx_pkg::A_BANK);
    chk(rd, 32'h0000_0001);
    wr(cbx_pkg::A_BANK, 32'h0000_0000);
    rdw(fa(7'h05));
    chk(rd, 32'h0000_003C);
    wr(cbx_pkg::A_INSTR, jw);
    wr(cbx_pkg::A_INSTR, mk(cbx_pkg::OP_NOP, 9'h000, 1'b0, 3'h0, 7'h00));
    rdw(cbx_pkg::A_STATUS);
    chk(rd & 32'h0000_0300, 32'h0000_0100);
    rdw(cbx_pkg::A_INSTR);
    chk(rd, jw);
    wr(cbx_pkg::A_STATUS, 32'h0000_0100);
    rdw(cbx_pkg::A_STATUS);
    chk(rd & 32'h0000_0100, 32'h0000_0000);
    $display("test misc done");
  endtask

  // Main sequence: reset for eight cycles, then every test in turn.
  initial begin
    fails    = 0;
    n_checks = 0;
    rst_n    = 1'b0;
    hsel     = 1'b0;
    haddr    = 32'h0000_0000;
    htrans   = 2'h0;
    hwrite   = 1'b0;
    hwdata   = 32'h0000_0000;
    repeat (8) @(posedge clk);
    rst_n <= 1'b1;
    @(posedge clk);
    t_and();
    t_addc();
    t_asr();
    t_bits();
    t_jumps();
    t_misc();
    end_of_test();
  end

  // Watchdog: the tests need well under a thousand cycles; 10000 means a hang.
  initial begin
    #100000;
    fails++;
    end_of_test();
  end
endmodule
